/* rtl/rivm_map.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// address former: selects base and adds slot offset
module rivm_map
	import rivm_pkg::*;
(
	input wire logic [IDX_W-1:0] idx,        // source index
	input wire logic is_reset,               // form the reset address
	input wire logic fuse_prog,              // reset placed at boot
	input wire logic sel_boot,               // vectors placed at boot
	input wire logic [PC_W-1:0] boot_addr,   // boot section start
	output logic [PC_W-1:0] addr             // formed address
);
	logic [PC_W-1:0] vec_base;

	// base from select bit, reset from fuse, chosen independently
	always_comb begin
		vec_base = sel_boot ? boot_addr : RESET_OFS;
		if (is_reset) begin
			addr = fuse_prog ? boot_addr : RESET_OFS;
		end else begin
			addr = PC_W'(vec_base + rivm_slot_ofs(idx));
		end
	end
endmodule
`default_nettype wire

/* rtl/rivm_pkg.sv */
// ==========================================================
// shared constants for the reset and interrupt vector map
package rivm_pkg;
	// ==========================================================
	// widths
	localparam int PC_W = 17;          // program word address width
	localparam int IDX_W = 5;          // source index width
	localparam int SRC_N = 30;         // interrupt sources, vectors 2..31
	localparam int CTL_W = 2;          // control write data width
	localparam int CTL_CE_BIT = 0;     // change enable field position
	localparam int CTL_SEL_BIT = 1;    // vector select field position
	localparam int CNT_W = 3;          // change window counter width

	// ==========================================================
	// values and timing
	localparam logic [PC_W-1:0] RESET_OFS = 17'h00000;
	localparam logic [PC_W-1:0] SLOT_ONE = 17'h00001;
	localparam logic [CNT_W-1:0] CE_WINDOW = 3'h4;
	localparam logic [CNT_W-1:0] CE_LAST = 3'h1;
	localparam logic FUSE_PROGRAMMED = 1'b0;
	localparam logic SEL_RESET = 1'b0;
	localparam logic CE_RESET = 1'b0;

	// ==========================================================
	// source indices (vector number minus two)
	localparam logic [IDX_W-1:0] SRC_EXT_IRQ_0 = 5'h00;
	localparam logic [IDX_W-1:0] SRC_EXT_IRQ_2 = 5'h02;
	localparam logic [IDX_W-1:0] SRC_PIN_CHANGE_IRQ_0 = 5'h03;
	localparam logic [IDX_W-1:0] SRC_PIN_CHANGE_IRQ_3 = 5'h06;
	localparam logic [IDX_W-1:0] SRC_WATCHDOG = 5'h07;
	localparam logic [IDX_W-1:0] SRC_TIMER_B8_MATCH_A = 5'h08;
	localparam logic [IDX_W-1:0] SRC_TIMER_W16_OVF = 5'h0E;
	localparam logic [IDX_W-1:0] SRC_TIMER_A8_MATCH_A = 5'h0F;
	localparam logic [IDX_W-1:0] SRC_SPI_DONE = 5'h12;
	localparam logic [IDX_W-1:0] SRC_SERIAL_A_RX_DONE = 5'h13;
	localparam logic [IDX_W-1:0] SRC_EEPROM_READY = 5'h18;
	localparam logic [IDX_W-1:0] SRC_TWO_WIRE = 5'h19;
	localparam logic [IDX_W-1:0] SRC_PROG_STORE_READY = 5'h1A;
	localparam logic [IDX_W-1:0] SRC_SERIAL_B_TX_DONE = 5'h1D;

	// ==========================================================
	// expected slot offsets for selected sources
	localparam logic [PC_W-1:0] OFS_EXT_IRQ_0 = 17'h00002;
	localparam logic [PC_W-1:0] OFS_EXT_IRQ_2 = 17'h00006;
	localparam logic [PC_W-1:0] OFS_PIN_CHANGE_IRQ_0 = 17'h00008;
	localparam logic [PC_W-1:0] OFS_PIN_CHANGE_IRQ_3 = 17'h0000E;
	localparam logic [PC_W-1:0] OFS_WATCHDOG = 17'h00010;
	localparam logic [PC_W-1:0] OFS_TIMER_B8_MATCH_A = 17'h00012;
	localparam logic [PC_W-1:0] OFS_TIMER_W16_OVF = 17'h0001E;
	localparam logic [PC_W-1:0] OFS_TIMER_A8_MATCH_A = 17'h00020;
	localparam logic [PC_W-1:0] OFS_SPI_DONE = 17'h00026;
	localparam logic [PC_W-1:0] OFS_SERIAL_A_RX_DONE = 17'h00028;
	localparam logic [PC_W-1:0] OFS_EEPROM_READY = 17'h00032;
	localparam logic [PC_W-1:0] OFS_TWO_WIRE = 17'h00034;
	localparam logic [PC_W-1:0] OFS_PROG_STORE_READY = 17'h00036;
	localparam logic [PC_W-1:0] OFS_SERIAL_B_TX_DONE = 17'h0003C;

	// ==========================================================
	// top level sequencing states, gray along the path
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_BOOT = 2'b01,
		ST_RUN = 2'b11
	} rivm_state_t;

	// slot offset: two words per vector, source 0 is vector 2
	function automatic logic [PC_W-1:0] rivm_slot_ofs(
		input logic [IDX_W-1:0] idx);
		logic [PC_W-1:0] n;
		n = PC_W'(idx) + SLOT_ONE;
		return PC_W'(n << 1);
	endfunction

	// true when the index names one of the sources
	function automatic logic rivm_is_src(input logic [IDX_W-1:0] idx);
		return 32'(idx) < SRC_N;
	endfunction
endpackage

/* rtl/rivm_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// reset and interrupt dispatch address generator
module rivm_top
	import rivm_pkg::*;
(
	input wire logic mclk,                      // system clock
	input wire logic reset_n,                   // sync reset, low
	input wire logic boot_reset_fuse,           // reset placement fuse
	input wire logic [PC_W-1:0] boot_start_addr, // boot section start
	input wire logic [SRC_N-1:0] irq_req,       // peripheral requests
	input wire logic irq_take,                  // core takes a source
	input wire logic [IDX_W-1:0] irq_num,       // index being taken
	input wire logic ctrl_wr,                   // core control write
	input wire logic [CTL_W-1:0] ctrl_wdata,    // core control data
	output logic dispatch_valid,                // fetch address valid
	output logic [PC_W-1:0] dispatch_addr,      // fetch target address
	output logic dispatch_reset,                // target is reset vector
	output logic irq_pending,                   // any request present
	output logic vector_select_boot,            // vectors at boot
	output logic vector_change_enable           // change window open
);
	// ==========================================================
	// state
	typedef struct packed {
		rivm_state_t state;
		logic fuse_prog;
		logic valid;
		logic is_reset;
		logic [PC_W-1:0] addr;
		logic pending;
	} rivm_top_st_t;

	rivm_top_st_t st_reg;
	rivm_top_st_t st_next;

	logic take_ok;
	logic map_reset;
	logic [PC_W-1:0] map_addr;

	// ==========================================================
	// vector select control
	rivm_vsel u_vsel (
		.mclk(mclk),
		.reset_n(reset_n),
		.ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata),
		.sel_boot(vector_select_boot),
		.ce_open(vector_change_enable)
	);

	// ==========================================================
	// address former
	rivm_map u_map (
		.idx(irq_num),
		.is_reset(map_reset),
		.fuse_prog(st_reg.fuse_prog),
		.sel_boot(vector_select_boot),
		.boot_addr(boot_start_addr),
		.addr(map_addr)
	);

	// ==========================================================
	// dispatch conditions
	// a take counts only for a real source that is requesting
	assign take_ok = (st_reg.state == ST_RUN) && irq_take &&
		rivm_is_src(irq_num) && irq_req[irq_num];
	assign map_reset = (st_reg.state == ST_BOOT);

	// ==========================================================
	// sequencing and dispatch
	always_comb begin
		st_next = st_reg;
		st_next.valid = 1'b0;
		st_next.is_reset = 1'b0;
		st_next.pending = |irq_req;
		case (st_reg.state)
			ST_RESET: begin
				// fuse caught once after release
				st_next.fuse_prog = (boot_reset_fuse == FUSE_PROGRAMMED);
				st_next.state = ST_BOOT;
			end
			ST_BOOT: begin
				// one reset fetch for any reset kind
				st_next.valid = 1'b1;
				st_next.is_reset = 1'b1;
				st_next.addr = map_addr;
				st_next.state = ST_RUN;
			end
			ST_RUN: begin
				// slot fetch only for a granted request
				if (take_ok) begin
					st_next.valid = 1'b1;
					st_next.addr = map_addr;
				end
			end
			default: begin
				st_next.state = ST_RESET;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_reg <= '{state: ST_RESET, fuse_prog: 1'b0, valid: 1'b0,
				is_reset: 1'b0, addr: RESET_OFS, pending: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign dispatch_valid = st_reg.valid;
	assign dispatch_addr = st_reg.addr;
	assign dispatch_reset = st_reg.is_reset;
	assign irq_pending = st_reg.pending;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// slot request taken with table at start of flash
	sequence s_take_app(logic [IDX_W-1:0] idx);
		take_ok && irq_num == idx && !vector_select_boot;
	endsequence

	// reset fetch follows release by two edges
	sequence s_reset_fetch;
		!dispatch_valid ##2 (dispatch_valid && dispatch_reset);
	endsequence

	property p_reset_seq;
		$rose(reset_n) |-> s_reset_fetch;
	endproperty
	a_reset_seq: assert property (p_reset_seq)
		else $error("reset fetch not issued after release");

	property p_reset_app;
		dispatch_valid && dispatch_reset && !st_reg.fuse_prog
			|-> dispatch_addr == RESET_OFS;
	endproperty
	a_reset_app: assert property (p_reset_app)
		else $error("unprogrammed fuse reset not at zero");

	property p_reset_boot;
		dispatch_valid && dispatch_reset && st_reg.fuse_prog
			|-> dispatch_addr == boot_start_addr;
	endproperty
	a_reset_boot: assert property (p_reset_boot)
		else $error("programmed fuse reset not at boot start");

	property p_slot_ext;
		s_take_app(SRC_EXT_IRQ_0) |=>
			dispatch_valid && dispatch_addr == OFS_EXT_IRQ_0;
	endproperty
	a_slot_ext: assert property (p_slot_ext)
		else $error("external request 0 slot wrong");

	property p_slot_pin;
		s_take_app(SRC_PIN_CHANGE_IRQ_3) |=>
			dispatch_addr == OFS_PIN_CHANGE_IRQ_3;
	endproperty
	a_slot_pin: assert property (p_slot_pin)
		else $error("pin change 3 slot wrong");

	property p_slot_wdt;
		s_take_app(SRC_WATCHDOG) |=> dispatch_addr == OFS_WATCHDOG;
	endproperty
	a_slot_wdt: assert property (p_slot_wdt)
		else $error("watchdog slot wrong");

	property p_slot_t16;
		s_take_app(SRC_TIMER_W16_OVF) |=>
			dispatch_addr == OFS_TIMER_W16_OVF;
	endproperty
	a_slot_t16: assert property (p_slot_t16)
		else $error("16-bit timer overflow slot wrong");

	property p_slot_spi;
		s_take_app(SRC_SPI_DONE) |=> dispatch_addr == OFS_SPI_DONE;
	endproperty
	a_slot_spi: assert property (p_slot_spi)
		else $error("spi slot wrong");

	property p_slot_twi;
		s_take_app(SRC_TWO_WIRE) |=> dispatch_addr == OFS_TWO_WIRE;
	endproperty
	a_slot_twi: assert property (p_slot_twi)
		else $error("two-wire slot wrong");

	property p_slot_serb;
		s_take_app(SRC_SERIAL_B_TX_DONE) |=>
			dispatch_addr == OFS_SERIAL_B_TX_DONE;
	endproperty
	a_slot_serb: assert property (p_slot_serb)
		else $error("second serial tx done slot wrong");

	property p_slot_ext2;
		s_take_app(SRC_EXT_IRQ_2) |=>
			dispatch_addr == OFS_EXT_IRQ_2;
	endproperty
	a_slot_ext2: assert property (p_slot_ext2)
		else $error("external request 2 slot wrong");

	property p_slot_pin0;
		s_take_app(SRC_PIN_CHANGE_IRQ_0) |=>
			dispatch_addr == OFS_PIN_CHANGE_IRQ_0;
	endproperty
	a_slot_pin0: assert property (p_slot_pin0)
		else $error("pin change 0 slot wrong");

	property p_slot_t8b;
		s_take_app(SRC_TIMER_B8_MATCH_A) |=>
			dispatch_addr == OFS_TIMER_B8_MATCH_A;
	endproperty
	a_slot_t8b: assert property (p_slot_t8b)
		else $error("second 8-bit timer match a slot wrong");

	property p_slot_t8a;
		s_take_app(SRC_TIMER_A8_MATCH_A) |=>
			dispatch_addr == OFS_TIMER_A8_MATCH_A;
	endproperty
	a_slot_t8a: assert property (p_slot_t8a)
		else $error("first 8-bit timer match a slot wrong");

	property p_slot_sera;
		s_take_app(SRC_SERIAL_A_RX_DONE) |=>
			dispatch_addr == OFS_SERIAL_A_RX_DONE;
	endproperty
	a_slot_sera: assert property (p_slot_sera)
		else $error("first serial rx done slot wrong");

	property p_slot_eep;
		s_take_app(SRC_EEPROM_READY) |=>
			dispatch_addr == OFS_EEPROM_READY;
	endproperty
	a_slot_eep: assert property (p_slot_eep)
		else $error("eeprom ready slot wrong");

	property p_slot_store;
		s_take_app(SRC_PROG_STORE_READY) |=>
			dispatch_addr == OFS_PROG_STORE_READY;
	endproperty
	a_slot_store: assert property (p_slot_store)
		else $error("program store ready slot wrong");

	property p_boot_base;
		take_ok && vector_select_boot && irq_num == SRC_WATCHDOG |=>
			dispatch_addr == PC_W'($past(boot_start_addr) + OFS_WATCHDOG);
	endproperty
	a_boot_base: assert property (p_boot_base)
		else $error("boot based slot wrong");

	property p_no_stray;
		st_reg.state == ST_RUN && !take_ok |=> !dispatch_valid;
	endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("fetch issued without reset or grant");

	property p_ce_close;
		ctrl_wr && ctrl_wdata[CTL_CE_BIT] ##1 (!ctrl_wr) [*4]
			|=> !vector_change_enable;
	endproperty
	a_ce_close: assert property (p_ce_close)
		else $error("change window not closed after four cycles");

	property p_sel_locked;
		ctrl_wr && !ctrl_wdata[CTL_CE_BIT] && !vector_change_enable
			|=> $stable(vector_select_boot);
	endproperty
	a_sel_locked: assert property (p_sel_locked)
		else $error("select changed outside window");

	property p_sel_taken;
		ctrl_wr && !ctrl_wdata[CTL_CE_BIT] && vector_change_enable
			|=> vector_select_boot == $past(ctrl_wdata[CTL_SEL_BIT]);
	endproperty
	a_sel_taken: assert property (p_sel_taken)
		else $error("select not taken inside window");

	// change procedure steps: arm, then commit inside the window
	sequence s_arm;
		ctrl_wr && ctrl_wdata[CTL_CE_BIT];
	endsequence

	sequence s_commit;
		ctrl_wr && !ctrl_wdata[CTL_CE_BIT] && vector_change_enable;
	endsequence

	property p_ce_open;
		s_arm |=> vector_change_enable;
	endproperty
	a_ce_open: assert property (p_ce_open)
		else $error("change window not opened by enable write");

	property p_ce_shut;
		s_commit |=> !vector_change_enable;
	endproperty
	a_ce_shut: assert property (p_ce_shut)
		else $error("change window left open after select write");

	property p_take_pulse;
		take_ok |=> dispatch_valid && !dispatch_reset;
	endproperty
	a_take_pulse: assert property (p_take_pulse)
		else $error("granted take gave no slot fetch");

	property p_addr_hold;
		st_reg.state == ST_RUN && !take_ok |=> $stable(dispatch_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved without a dispatch");

	property p_app_table;
		take_ok && !vector_select_boot |=>
			dispatch_addr >= OFS_EXT_IRQ_0 &&
			dispatch_addr <= OFS_SERIAL_B_TX_DONE;
	endproperty
	a_app_table: assert property (p_app_table)
		else $error("slot outside table at flash start");

	property p_pend_set;
		(|irq_req) |=> irq_pending;
	endproperty
	a_pend_set: assert property (p_pend_set)
		else $error("pending not raised by a request");

	property p_pend_clr;
		!(|irq_req) |=> !irq_pending;
	endproperty
	a_pend_clr: assert property (p_pend_clr)
		else $error("pending raised with no request");
endmodule
`default_nettype wire

/* rtl/rivm_vsel.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// vector select bit with its timed change procedure
module rivm_vsel
	import rivm_pkg::*;
(
	input wire logic mclk,                   // system clock
	input wire logic reset_n,                // sync reset, low
	input wire logic ctrl_wr,                // control write strobe
	input wire logic [CTL_W-1:0] ctrl_wdata, // control write data
	output logic sel_boot,                   // vector select state
	output logic ce_open                     // change enable state
);
	typedef struct packed {
		logic sel;
		logic ce;
		logic [CNT_W-1:0] cnt;
	} rivm_vsel_st_t;

	rivm_vsel_st_t st_reg;
	rivm_vsel_st_t st_next;

	// arm on enable write, take select only while armed
	always_comb begin
		st_next = st_reg;
		if (ctrl_wr && ctrl_wdata[CTL_CE_BIT]) begin
			st_next.ce = 1'b1;
			st_next.cnt = CE_WINDOW;
		end else if (ctrl_wr && st_reg.ce) begin
			st_next.sel = ctrl_wdata[CTL_SEL_BIT];
			st_next.ce = 1'b0;
		end else if (st_reg.ce) begin
			st_next.cnt = st_reg.cnt - CE_LAST;
			st_next.ce = (st_reg.cnt != CE_LAST);
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_reg <= '{sel: SEL_RESET, ce: CE_RESET, cnt: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign sel_boot = st_reg.sel;
	assign ce_open = st_reg.ce;
endmodule
`default_nettype wire

/* sim/rivm_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// core fetch side and peripheral request lines
module rivm_core_model
	import rivm_pkg::*;
(
	input wire logic mclk,              // system clock
	output logic [SRC_N-1:0] irq_req,   // peripheral requests
	output logic irq_take,              // core takes a source
	output logic [IDX_W-1:0] irq_num,   // index being taken
	output logic ctrl_wr,               // control write strobe
	output logic [CTL_W-1:0] ctrl_wdata // control write data
);
	// idle values from time zero
	initial begin
		irq_req = '1;
		irq_take = 1'b0;
		irq_num = 5'h00;
		ctrl_wr = 1'b0;
		ctrl_wdata = 2'h0;
	end

	// request levels, changed at a clock edge by the caller
	task automatic set_req(input logic [SRC_N-1:0] req);
		irq_req <= req;
	endtask

	// take strobe and index, changed at a clock edge by the caller
	task automatic set_take(input logic on, input logic [IDX_W-1:0] idx);
		irq_take <= on;
		irq_num <= idx;
	endtask

	// one write, held up to its sampling edge, data scrambled after
	task automatic ctrl_write(input logic ce, input logic sel);
		@(posedge mclk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= {sel, ce};
		@(posedge mclk);
		ctrl_wr <= 1'b0;
		ctrl_wdata <= ~{sel, ce};
	endtask

	// timed change: enable first, value with enable low after gap
	task automatic change_sel(input logic sel, input int gap);
		ctrl_write(1'b1, 1'b0);
		repeat (gap) @(posedge mclk);
		ctrl_write(1'b0, sel);
	endtask
endmodule
`default_nettype wire

/* sim/tb_reset_irq_vector_map.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the vector map
module tb_reset_irq_vector_map
	import rivm_pkg::*;
;
	localparam logic [PC_W-1:0] BOOT_BASE = 17'h1F000;
	localparam int LIMIT = 5000;
	logic mclk;
	logic reset_n;
	logic boot_reset_fuse;
	logic [PC_W-1:0] boot_start_addr;
	logic [SRC_N-1:0] irq_req;
	logic irq_take;
	logic [IDX_W-1:0] irq_num;
	logic ctrl_wr;
	logic [CTL_W-1:0] ctrl_wdata;
	logic dispatch_valid;
	logic [PC_W-1:0] dispatch_addr;
	logic dispatch_reset;
	logic irq_pending;
	logic vector_select_boot;
	logic vector_change_enable;
	int err_total = 0;
	int n_tests = 0;
	int cycles = 0;

	// ==========================================================
	// design and far side
	rivm_top rivm_top_inst (
		.mclk(mclk),
		.reset_n(reset_n),
		.boot_reset_fuse(boot_reset_fuse),
		.boot_start_addr(boot_start_addr),
		.irq_req(irq_req),
		.irq_take(irq_take),
		.irq_num(irq_num),
		.ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata),
		.dispatch_valid(dispatch_valid),
		.dispatch_addr(dispatch_addr),
		.dispatch_reset(dispatch_reset),
		.irq_pending(irq_pending),
		.vector_select_boot(vector_select_boot),
		.vector_change_enable(vector_change_enable)
	);
	rivm_core_model rivm_core_model_inst (
		.mclk(mclk),
		.irq_req(irq_req),
		.irq_take(irq_take),
		.irq_num(irq_num),
		.ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata)
	);

	// ==========================================================
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			err_total = err_total + 1;
			end_sim();
		end
	end

	// ==========================================================
	// helpers
	function automatic logic [PC_W-1:0] vec_ofs(input int i);
		return PC_W'(2 * (i + 1));
	endfunction
	task automatic cmp(input logic [PC_W-1:0] got, exp, input string what);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_d(input logic v, r, input logic [PC_W-1:0] a);
		cmp(PC_W'(dispatch_valid), PC_W'(v), "dispatch valid");
		cmp(PC_W'(dispatch_reset), PC_W'(r), "dispatch reset");
		if (v) begin
			cmp(dispatch_addr, a, "dispatch address");
		end
	endtask
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	// reset with a take held high that must be ignored
	task automatic do_reset(input logic fuse);
		logic [PC_W-1:0] e;
		e = (fuse === FUSE_PROGRAMMED) ? BOOT_BASE : 17'h00000;
		@(posedge mclk);
		reset_n <= 1'b0;
		boot_reset_fuse <= fuse;
		rivm_core_model_inst.set_take(1'b1, 5'h00);
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		#1;
		chk_d(1'b0, 1'b0, 17'h00000);
		repeat (2) @(posedge mclk);
		rivm_core_model_inst.set_take(1'b0, 5'h00);
		#1;
		chk_d(1'b1, 1'b1, e);
		@(posedge mclk);
		#1;
		chk_d(1'b0, 1'b0, e);
		cmp(PC_W'(vector_select_boot), 17'h00000, "select");
	endtask
	// every source back to back
	task automatic scan(input logic [PC_W-1:0] base);
		for (int i = 0; i <= SRC_N; i++) begin
			@(posedge mclk);
			rivm_core_model_inst.set_take(i < SRC_N, IDX_W'(i));
			#1;
			if (i > 0) begin
				chk_d(1'b1, 1'b0, base + vec_ofs(i - 1));
			end
		end
	endtask
	task automatic one_take(input logic [IDX_W-1:0] idx,
		input logic [PC_W-1:0] e);
		@(posedge mclk);
		rivm_core_model_inst.set_take(1'b1, idx);
		@(posedge mclk);
		rivm_core_model_inst.set_take(1'b0, 5'h00);
		#1;
		chk_d(1'b1, 1'b0, e);
		@(posedge mclk);
		#1;
		chk_d(1'b0, 1'b0, e);
	endtask
	// quiet source and out-of-range index give nothing, address holds
	task automatic take_refused(input logic [PC_W-1:0] held);
		@(posedge mclk);
		rivm_core_model_inst.set_req(30'h3FFFFFDF);
		@(posedge mclk);
		rivm_core_model_inst.set_take(1'b1, 5'h05);
		@(posedge mclk);
		rivm_core_model_inst.set_take(1'b1, 5'h1E);
		@(posedge mclk);
		rivm_core_model_inst.set_take(1'b0, 5'h00);
		#1;
		chk_d(1'b0, 1'b0, held);
		@(posedge mclk);
		rivm_core_model_inst.set_req('1);
		#1;
		chk_d(1'b0, 1'b0, held);
		cmp(dispatch_addr, held, "held address");
		cmp(PC_W'(irq_pending), 17'h00001, "pending");
		@(posedge mclk);
		rivm_core_model_inst.set_req('0);
		@(posedge mclk);
		rivm_core_model_inst.set_req('1);
		#1;
		cmp(PC_W'(irq_pending), 17'h00000, "pending low");
		@(posedge mclk);
		#1;
		cmp(PC_W'(irq_pending), 17'h00001, "pending again");
	endtask
	// lone write and late write are both ignored
	task automatic sel_refused();
		rivm_core_model_inst.ctrl_write(1'b0, 1'b1);
		#1;
		cmp(PC_W'(vector_select_boot), 17'h00000, "lone write");
		rivm_core_model_inst.ctrl_write(1'b1, 1'b0);
		#1;
		cmp(PC_W'(vector_change_enable), 17'h00001, "open");
		repeat (3) @(posedge mclk);
		#1;
		cmp(PC_W'(vector_change_enable), 17'h00001, "still open");
		@(posedge mclk);
		#1;
		cmp(PC_W'(vector_change_enable), 17'h00000, "closed");
		rivm_core_model_inst.ctrl_write(1'b0, 1'b1);
		#1;
		cmp(PC_W'(vector_select_boot), 17'h00000, "late write");
	endtask
	task automatic sel_change_ok(input logic sel, input int gap);
		rivm_core_model_inst.change_sel(sel, gap);
		#1;
		cmp(PC_W'(vector_select_boot), PC_W'(sel), "select");
		cmp(PC_W'(vector_change_enable), 17'h00000, "closed");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		boot_reset_fuse = 1'b1;
		boot_start_addr = BOOT_BASE;
		do_reset(1'b1);
		scan(17'h00000);
		take_refused(17'h0003C);
		sel_refused();
		sel_change_ok(1'b1, 0);
		scan(BOOT_BASE);
		sel_change_ok(1'b0, 2);
		one_take(5'h07, 17'h00010);
		do_reset(1'b0);
		one_take(5'h00, 17'h00002);
		sel_change_ok(1'b1, 2);
		one_take(5'h1D, BOOT_BASE + 17'h0003C);
		end_sim();
	end
endmodule
`default_nettype wire
